// ---- common/pib_consts.vh ----
// Offsets, fields, reset values and timing for the protector self-check
`ifndef PIB_CONSTS_VH
`define PIB_CONSTS_VH

// Register byte offsets
`define PIB_OFF_VCTRL   8'h00
`define PIB_OFF_TCTRL   8'h04
`define PIB_OFF_THR     8'h08
`define PIB_OFF_CELLS   8'h0c
`define PIB_OFF_GPIOCF  8'h10
`define PIB_OFF_DIAG    8'h14
`define PIB_OFF_STAT1   8'h18
`define PIB_OFF_STAT2   8'h1c
`define PIB_OFF_UVFLG   8'h20
`define PIB_OFF_OVFLG   8'h24
`define PIB_OFF_TFLG    8'h28
`define PIB_OFF_STATE   8'h2c

// Control register fields
`define PIB_GO_BIT      2
`define PIB_LOCK_LSB    3

// Diag control fields
`define PIB_KEEP_BIT    0
`define PIB_DSEL_LSB    1
`define PIB_INJ_BIT     3

// Protector modes
`define PIB_MODE_OFF    2'h0
`define PIB_MODE_RR     2'h1
`define PIB_MODE_BIST   2'h2
`define PIB_MODE_SINGLE 2'h3

// Reset values
`define PIB_THR_RST     32'h00000000
`define PIB_CELLS_RST   16'hffff
`define PIB_GPIOCF_RST  32'h00000000

// DAC scaling for the voltage thresholds: 4/5 = 0.8
`define PIB_DAC_NUM     4
`define PIB_DAC_DEN     5

// Timing
`define PIB_CLK_MHZ     25
`define PIB_DWELL_NS    1000
`define PIB_PAR_US      100

`endif

// ---- src/pib_protector_bist.v ----
// Protector parity check, DAC readback routing and self-test engines
`include "pib_consts.vh"

// Engine for one protector: round robin, self-test, flags, parity
module pib_prot_engine #(
   parameter NCH     = 16,
   parameter CW      = 4,
   parameter TW      = 8,
   parameter DWELL   = 25,
   parameter PAR_CYC = 2500
) (
   input  wire          clk,
   input  wire          rst,
   input  wire          go,
   input  wire [1:0]    mode,
   input  wire [CW-1:0] lock,
   input  wire [TW-1:0] thr_hi,
   input  wire [TW-1:0] thr_lo,
   input  wire [NCH-1:0] active,
   input  wire          keep_flags,
   input  wire          par_inject,
   input  wire          cmp_hi,
   input  wire          cmp_lo,
   input  wire          alert_n,
   input  wire [NCH-1:0] clr_hi,
   input  wire [NCH-1:0] clr_lo,
   output reg  [CW-1:0] chan_r,
   output wire          cmp_en,
   output wire          drive_hi,
   output wire          drive_lo,
   output wire          force_lo,
   output reg  [NCH-1:0] hi_flags_r,
   output reg  [NCH-1:0] lo_flags_r,
   output reg  [4:0]    evt_r,
   output reg  [2:0]    state_r
);
   localparam S_OFF   = 3'd0;
   localparam S_RUN   = 3'd1;
   localparam S_CMPH  = 3'd2;
   localparam S_CMPL  = 3'd3;
   localparam S_PATH  = 3'd4;
   localparam S_FORCE = 3'd5;
   localparam [31:0]   LAST_I  = NCH - 1;
   localparam [31:0]   DW_I    = DWELL - 1;
   localparam [31:0]   PAR_I   = PAR_CYC - 1;
   localparam [CW-1:0] LAST    = LAST_I[CW-1:0];
   localparam [15:0]   DW_END  = DW_I[15:0];
   localparam [15:0]   PAR_END = PAR_I[15:0];

   reg [2:0]     state_nxt;
   reg [1:0]     ph_r;
   reg [1:0]     ph_nxt;
   reg [15:0]    tmr_r;
   reg [15:0]    tmr_nxt;
   reg [CW-1:0]  chan_nxt;
   reg [NCH-1:0] hi_set;
   reg [NCH-1:0] lo_set;
   reg [NCH-1:0] hi_clr;
   reg [NCH-1:0] lo_clr;
   reg [4:0]     evt_nxt;
   reg           latch;
   reg [TW-1:0]  thr_hi_l;
   reg [TW-1:0]  thr_lo_l;
   reg [1:0]     mode_l;
   reg [NCH-1:0] mask_l;
   reg [CW-1:0]  lock_l;
   reg           par_ref_r;
   reg [15:0]    par_cnt_r;

   wire [NCH-1:0] chbit = {{(NCH-1){1'b0}}, 1'b1} << chan_r;
   wire dwell_done = (tmr_r == DW_END);
   wire any_flags  = |{hi_flags_r, lo_flags_r};
   wire [CW-1:0] chan_inc = chan_r + {{(CW-1){1'b0}}, 1'b1};
   wire [CW-1:0] next_ch  = (chan_r == LAST) ? {CW{1'b0}} : chan_inc;
   wire cur_act = mask_l[chan_r];

   assign cmp_en   = (state_r != S_OFF);
   assign drive_hi = (state_r == S_CMPH);
   assign drive_lo = (state_r == S_CMPL);
   assign force_lo = (state_r == S_PATH) && (ph_r == 2'd0) && cur_act;

   always @* begin
      state_nxt = state_r;
      ph_nxt    = ph_r;
      tmr_nxt   = tmr_r + 16'h0001;
      chan_nxt  = chan_r;
      hi_set    = {NCH{1'b0}};
      lo_set    = {NCH{1'b0}};
      hi_clr    = {NCH{1'b0}};
      lo_clr    = {NCH{1'b0}};
      evt_nxt   = 5'h00;
      latch     = 1'b0;
      case (state_r)
         S_OFF: begin
            tmr_nxt = 16'h0000;
         end
         S_RUN: begin
            if (!cur_act) begin
               tmr_nxt = 16'h0000;
               if (mode_l == `PIB_MODE_RR)
                  chan_nxt = next_ch;
            end else if (dwell_done) begin
               hi_set  = chbit & {NCH{cmp_hi}};
               lo_set  = chbit & {NCH{cmp_lo}};
               tmr_nxt = 16'h0000;
               if (mode_l == `PIB_MODE_RR)
                  chan_nxt = next_ch;
            end
         end
         S_CMPH: begin
            if (dwell_done) begin
               evt_nxt[0] = ~cmp_hi;
               state_nxt  = S_CMPL;
               tmr_nxt    = 16'h0000;
            end
         end
         S_CMPL: begin
            if (dwell_done) begin
               evt_nxt[1] = ~cmp_lo;
               tmr_nxt    = 16'h0000;
               chan_nxt   = {CW{1'b0}};
               ph_nxt     = 2'd0;
               if (any_flags) begin
                  evt_nxt[3] = 1'b1;
                  state_nxt  = S_OFF;
               end else begin
                  state_nxt = S_PATH;
               end
            end
         end
         S_PATH, S_FORCE: begin
            if (!cur_act || ph_r == 2'd3) begin
               ph_nxt  = 2'd0;
               tmr_nxt = 16'h0000;
               if (chan_r == LAST) begin
                  chan_nxt  = {CW{1'b0}};
                  state_nxt = (state_r == S_PATH) ? S_FORCE : S_OFF;
               end else begin
                  chan_nxt = chan_inc;
               end
            end else if (ph_r == 2'd0) begin
               if (state_r == S_FORCE) begin
                  hi_set = chbit;
                  ph_nxt = 2'd1;
               end else if (dwell_done) begin
                  lo_set = chbit & {NCH{cmp_lo}};
                  ph_nxt = 2'd1;
               end
            end else if (ph_r == 2'd1) begin
               // Alert pin is registered one cycle behind the flags
               ph_nxt = 2'd2;
            end else begin
               if (state_r == S_PATH) begin
                  evt_nxt[2] = ~|(lo_flags_r & chbit) | alert_n;
                  if (!keep_flags)
                     lo_clr = chbit;
               end else begin
                  evt_nxt[2] = ~|(hi_flags_r & chbit) | alert_n;
                  if (!keep_flags)
                     hi_clr = chbit;
               end
               ph_nxt = 2'd3;
            end
         end
         default: begin
            state_nxt = S_OFF;
         end
      endcase
      // A new go always wins over a running sequence
      if (go) begin
         latch    = 1'b1;
         tmr_nxt  = 16'h0000;
         ph_nxt   = 2'd0;
         chan_nxt = (mode == `PIB_MODE_SINGLE) ? lock : {CW{1'b0}};
         case (mode)
            `PIB_MODE_RR, `PIB_MODE_SINGLE: state_nxt = S_RUN;
            `PIB_MODE_BIST: begin
               if (any_flags) begin
                  evt_nxt[3] = 1'b1;
                  state_nxt  = S_OFF;
               end else begin
                  state_nxt = S_CMPH;
               end
            end
            default: state_nxt = S_OFF;
         endcase
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r    <= S_OFF;
         ph_r       <= 2'd0;
         tmr_r      <= 16'h0000;
         chan_r     <= {CW{1'b0}};
         hi_flags_r <= {NCH{1'b0}};
         lo_flags_r <= {NCH{1'b0}};
         evt_r      <= 5'h00;
         thr_hi_l   <= {TW{1'b0}};
         thr_lo_l   <= {TW{1'b0}};
         mode_l     <= `PIB_MODE_OFF;
         mask_l     <= {NCH{1'b0}};
         lock_l     <= {CW{1'b0}};
         par_ref_r  <= 1'b0;
         par_cnt_r  <= 16'h0000;
      end else begin
         state_r    <= state_nxt;
         ph_r       <= ph_nxt;
         tmr_r      <= tmr_nxt;
         chan_r     <= chan_nxt;
         // Set wins over any clear in the same cycle
         hi_flags_r <= (hi_flags_r & ~(clr_hi | hi_clr)) | hi_set;
         lo_flags_r <= (lo_flags_r & ~(clr_lo | lo_clr)) | lo_set;
         evt_r      <= evt_nxt;
         if (latch) begin
            thr_hi_l  <= thr_hi;
            thr_lo_l  <= thr_lo;
            mode_l    <= mode;
            mask_l    <= active;
            lock_l    <= lock;
            par_ref_r <= ^{thr_hi, thr_lo, mode, active, lock};
            par_cnt_r <= 16'h0000;
         end else if (state_r != S_OFF) begin
            if (par_cnt_r == PAR_END) begin
               par_cnt_r <= 16'h0000;
               evt_r[4]  <= par_inject ^ par_ref_r ^
                  (^{thr_hi_l, thr_lo_l, mode_l, mask_l, lock_l});
            end else begin
               par_cnt_r <= par_cnt_r + 16'h0001;
            end
         end
      end
   end
endmodule // pib_prot_engine

module pib_protector_bist #(
   parameter DWELL   = (`PIB_DWELL_NS * `PIB_CLK_MHZ + 999) / 1000,
   parameter PAR_CYC = `PIB_PAR_US * `PIB_CLK_MHZ
) (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [7:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_stb_i,
   input  wire        wb_cyc_i,
   output wire        wb_ack_o,
   input  wire        v_cmp_ov,
   input  wire        v_cmp_uv,
   output wire [3:0]  v_chan_sel,
   output wire        v_cmp_en,
   output wire        v_drive_hi,
   output wire        v_drive_lo,
   output wire        v_sw_open,
   input  wire        t_cmp_ot,
   input  wire        t_cmp_ut,
   output wire [2:0]  t_chan_sel,
   output wire        t_cmp_en,
   output wire        t_drive_hi,
   output wire        t_drive_lo,
   output wire        t_pullup,
   output wire [7:0]  aux_dac_o,
   output wire        fault_alert_pin_n
);
   reg  [6:0]  vctrl_r;
   reg  [5:0]  tctrl_r;
   reg  [31:0] thr_r;
   reg  [15:0] cells_r;
   reg  [31:0] gpiocf_r;
   reg  [3:0]  diag_r;
   reg  [1:0]  stat1_r;
   reg  [6:0]  stat2_r;
   reg         ack_r;
   reg  [31:0] dat_r;
   reg  [7:0]  aux_dac_r;
   reg         alert_n_r;
   reg  [31:0] rd_nxt;
   reg  [7:0]  dac_nxt;

   wire [15:0] v_ovf;
   wire [15:0] v_uvf;
   wire [7:0]  t_otf;
   wire [7:0]  t_utf;
   wire [4:0]  v_evt;
   wire [4:0]  t_evt;
   wire [2:0]  v_state;
   wire [2:0]  t_state;

   // Classic Wishbone: one wait state, ack for one cycle
   wire        req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire        wr  = req & wb_we_i;
   wire [7:0]  adr = {wb_adr_i[7:2], 2'b00};
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wbits = wb_dat_i & wmask;
   wire [31:0] vctrl_new = ({25'h0, vctrl_r} & ~wmask) | wbits;
   wire [31:0] tctrl_new = ({26'h0, tctrl_r} & ~wmask) | wbits;
   wire wr_vctrl = wr && (adr == `PIB_OFF_VCTRL);
   wire wr_tctrl = wr && (adr == `PIB_OFF_TCTRL);
   wire v_go = wr_vctrl && wbits[`PIB_GO_BIT];
   wire t_go = wr_tctrl && wbits[`PIB_GO_BIT];
   wire [15:0] clr_uv = (wr && adr == `PIB_OFF_UVFLG) ? wbits[15:0] : 16'h0;
   wire [15:0] clr_ov = (wr && adr == `PIB_OFF_OVFLG) ? wbits[15:0] : 16'h0;
   wire [7:0]  clr_ut = (wr && adr == `PIB_OFF_TFLG) ? wbits[7:0] : 8'h0;
   wire [7:0]  clr_ot = (wr && adr == `PIB_OFF_TFLG) ? wbits[15:8] : 8'h0;
   // Bit 0 of each gpio config nibble marks a thermistor input
   wire [7:0]  gpio_act = {gpiocf_r[28], gpiocf_r[24], gpiocf_r[20],
                           gpiocf_r[16], gpiocf_r[12], gpiocf_r[8],
                           gpiocf_r[4], gpiocf_r[0]};

   // Voltage DAC runs at 0.8 of the threshold code
   wire [31:0] ov_prod = {24'h0, thr_r[7:0]} * `PIB_DAC_NUM;
   wire [31:0] uv_prod = {24'h0, thr_r[15:8]} * `PIB_DAC_NUM;
   wire [31:0] ov_quo  = ov_prod / `PIB_DAC_DEN;
   wire [31:0] uv_quo  = uv_prod / `PIB_DAC_DEN;

   assign wb_ack_o          = ack_r;
   assign wb_dat_o          = dat_r;
   assign aux_dac_o         = aux_dac_r;
   assign fault_alert_pin_n = alert_n_r;

   pib_prot_engine #(
      .NCH     (16),
      .CW      (4),
      .TW      (8),
      .DWELL   (DWELL),
      .PAR_CYC (PAR_CYC)
   ) u_volt (
      .clk        (sys_clk),
      .rst        (rst),
      .go         (v_go),
      .mode       (vctrl_new[1:0]),
      .lock       (vctrl_new[6:3]),
      .thr_hi     (thr_r[7:0]),
      .thr_lo     (thr_r[15:8]),
      .active     (cells_r),
      .keep_flags (diag_r[`PIB_KEEP_BIT]),
      .par_inject (diag_r[`PIB_INJ_BIT]),
      .cmp_hi     (v_cmp_ov),
      .cmp_lo     (v_cmp_uv),
      .alert_n    (alert_n_r),
      .clr_hi     (clr_ov),
      .clr_lo     (clr_uv),
      .chan_r     (v_chan_sel),
      .cmp_en     (v_cmp_en),
      .drive_hi   (v_drive_hi),
      .drive_lo   (v_drive_lo),
      .force_lo   (v_sw_open),
      .hi_flags_r (v_ovf),
      .lo_flags_r (v_uvf),
      .evt_r      (v_evt),
      .state_r    (v_state)
   );

   pib_prot_engine #(
      .NCH     (8),
      .CW      (3),
      .TW      (8),
      .DWELL   (DWELL),
      .PAR_CYC (PAR_CYC)
   ) u_temp (
      .clk        (sys_clk),
      .rst        (rst),
      .go         (t_go),
      .mode       (tctrl_new[1:0]),
      .lock       (tctrl_new[5:3]),
      .thr_hi     (thr_r[23:16]),
      .thr_lo     (thr_r[31:24]),
      .active     (gpio_act),
      .keep_flags (diag_r[`PIB_KEEP_BIT]),
      .par_inject (diag_r[`PIB_INJ_BIT]),
      .cmp_hi     (t_cmp_ot),
      .cmp_lo     (t_cmp_ut),
      .alert_n    (alert_n_r),
      .clr_hi     (clr_ot),
      .clr_lo     (clr_ut),
      .chan_r     (t_chan_sel),
      .cmp_en     (t_cmp_en),
      .drive_hi   (t_drive_hi),
      .drive_lo   (t_drive_lo),
      .force_lo   (t_pullup),
      .hi_flags_r (t_otf),
      .lo_flags_r (t_utf),
      .evt_r      (t_evt),
      .state_r    (t_state)
   );

   always @* begin
      case (diag_r[2:1])
         2'd0:    dac_nxt = ov_quo[7:0];
         2'd1:    dac_nxt = uv_quo[7:0];
         2'd2:    dac_nxt = thr_r[23:16];
         default: dac_nxt = thr_r[31:24];
      endcase
   end

   always @* begin
      case (adr)
         `PIB_OFF_VCTRL:  rd_nxt = {25'h0, vctrl_r};
         `PIB_OFF_TCTRL:  rd_nxt = {26'h0, tctrl_r};
         `PIB_OFF_THR:    rd_nxt = thr_r;
         `PIB_OFF_CELLS:  rd_nxt = {16'h0, cells_r};
         `PIB_OFF_GPIOCF: rd_nxt = gpiocf_r;
         `PIB_OFF_DIAG:   rd_nxt = {28'h0, diag_r};
         `PIB_OFF_STAT1:  rd_nxt = {30'h0, stat1_r};
         `PIB_OFF_STAT2:  rd_nxt = {25'h0, stat2_r};
         `PIB_OFF_UVFLG:  rd_nxt = {16'h0, v_uvf};
         `PIB_OFF_OVFLG:  rd_nxt = {16'h0, v_ovf};
         `PIB_OFF_TFLG:   rd_nxt = {16'h0, t_otf, t_utf};
         `PIB_OFF_STATE:  rd_nxt = {16'h0, aux_dac_r, 1'b0, t_state,
                                    1'b0, v_state};
         default:         rd_nxt = 32'h0;
      endcase
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vctrl_r   <= 7'h00;
         tctrl_r   <= 6'h00;
         thr_r     <= `PIB_THR_RST;
         cells_r   <= `PIB_CELLS_RST;
         gpiocf_r  <= `PIB_GPIOCF_RST;
         diag_r    <= 4'h0;
         stat1_r   <= 2'h0;
         stat2_r   <= 7'h00;
         ack_r     <= 1'b0;
         dat_r     <= 32'h0;
         aux_dac_r <= 8'h00;
         alert_n_r <= 1'b1;
      end else begin
         ack_r     <= req;
         aux_dac_r <= dac_nxt;
         alert_n_r <= ~|{v_ovf, v_uvf, t_otf, t_utf};
         if (req)
            dat_r <= wb_we_i ? 32'h0 : rd_nxt;
         // Go bit is a strobe and never stored
         if (wr_vctrl)
            vctrl_r <= {vctrl_new[6:3], 1'b0, vctrl_new[1:0]};
         if (wr_tctrl)
            tctrl_r <= {tctrl_new[5:3], 1'b0, tctrl_new[1:0]};
         if (wr && adr == `PIB_OFF_THR)
            thr_r <= (thr_r & ~wmask) | wbits;
         if (wr && adr == `PIB_OFF_CELLS)
            cells_r <= (cells_r & ~wmask[15:0]) | wbits[15:0];
         if (wr && adr == `PIB_OFF_GPIOCF)
            gpiocf_r <= (gpiocf_r & ~wmask) | wbits;
         if (wr && adr == `PIB_OFF_DIAG)
            diag_r <= (diag_r & ~wmask[3:0]) | wbits[3:0];
         // Write one to clear; a new event in the same cycle wins
         stat1_r <= (stat1_r & ~((wr && adr == `PIB_OFF_STAT1) ?
                     wbits[1:0] : 2'h0)) | {t_evt[4], v_evt[4]};
         stat2_r <= (stat2_r & ~((wr && adr == `PIB_OFF_STAT2) ?
                     wbits[6:0] : 7'h00)) |
                    {v_evt[3] | t_evt[3], t_evt[2], v_evt[2],
                     t_evt[1], t_evt[0], v_evt[1], v_evt[0]};
      end
   end
endmodule // pib_protector_bist

// ---- tb/pib_protector_bist_checker.sv ----
// Port assertions for the protector self-check block
module pib_protector_bist_checker (
   input logic       sys_clk,
   input logic       rst,
   input logic       wb_cyc_i,
   input logic       wb_stb_i,
   input logic       wb_ack_o,
   input logic       v_cmp_uv,
   input logic [3:0] v_chan_sel,
   input logic       v_cmp_en,
   input logic       v_drive_hi,
   input logic       v_drive_lo,
   input logic       v_sw_open,
   input logic       t_cmp_ut,
   input logic [2:0] t_chan_sel,
   input logic       t_cmp_en,
   input logic       t_drive_hi,
   input logic       t_drive_lo,
   input logic       t_pullup,
   input logic       fault_alert_pin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Forced input held and seen by the comparator
   sequence s_vpath;
      (v_sw_open && v_cmp_uv) [*2];
   endsequence
   sequence s_tpath;
      (t_pullup && t_cmp_ut) [*2];
   endsequence
   a_ack_follows: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Request not answered next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack longer than one cycle");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("Ack without request");
   a_vdrive_gated: assert property
      (v_drive_hi || v_drive_lo || v_sw_open |-> v_cmp_en)
      else $error("Voltage drive while comparators off");
   a_tdrive_gated: assert property
      (t_drive_hi || t_drive_lo || t_pullup |-> t_cmp_en)
      else $error("Temperature drive while comparators off");
   a_vlo_after_hi: assert property
      ($rose(v_drive_lo) |-> $past(v_drive_hi))
      else $error("Voltage low drive not after high drive");
   a_tlo_after_hi: assert property
      ($rose(t_drive_lo) |-> $past(t_drive_hi))
      else $error("Temperature low drive not after high drive");
   a_vpath_alert: assert property
      (s_vpath |-> ##[0:6] !fault_alert_pin_n)
      else $error("Alert missing in voltage path step");
   a_tpath_alert: assert property
      (s_tpath |-> ##[0:6] !fault_alert_pin_n)
      else $error("Alert missing in temperature path step");
   a_vsel_hold: assert property
      (v_sw_open && $past(v_sw_open) |-> $stable(v_chan_sel))
      else $error("Voltage channel moved during path step");
   a_tsel_hold: assert property
      (t_pullup && $past(t_pullup) |-> $stable(t_chan_sel))
      else $error("Gpio channel moved during path step");
endmodule // pib_protector_bist_checker

bind pib_protector_bist pib_protector_bist_checker u_chk (
   .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .v_cmp_uv,
   .v_chan_sel, .v_cmp_en, .v_drive_hi, .v_drive_lo, .v_sw_open,
   .t_cmp_ut, .t_chan_sel, .t_cmp_en, .t_drive_hi, .t_drive_lo,
   .t_pullup, .fault_alert_pin_n);

// ---- tb/pib_afe_model.sv ----
// Comparator front end: trips on self-test drive or a commanded fault
module pib_afe_model (
   input  logic       v_drive_hi,
   input  logic       v_drive_lo,
   input  logic       v_sw_open,
   input  logic       t_drive_hi,
   input  logic       t_drive_lo,
   input  logic       t_pullup,
   input  logic [3:0] stuck,
   input  logic       cell_uv,
   output logic       v_cmp_ov,
   output logic       v_cmp_uv,
   output logic       t_cmp_ot,
   output logic       t_cmp_ut
);
   timeunit 1ns;
   timeprecision 1ns;
   // Inputs sit well inside both thresholds unless a test says otherwise
   assign v_cmp_ov = v_drive_hi & ~stuck[0];
   assign v_cmp_uv = (v_drive_lo | v_sw_open | cell_uv) & ~stuck[1];
   assign t_cmp_ot = t_drive_hi & ~stuck[2];
   assign t_cmp_ut = (t_drive_lo | t_pullup) & ~stuck[3];
endmodule // pib_afe_model

// ---- tb/pib_protector_bist_test.sv ----
// Self-checking bench for the protector self-check block
`include "pib_consts.vh"
module pib_protector_bist_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DW = 2;
   localparam int PC = 8;
   typedef struct packed {
      logic        we;
      logic [7:0]  adr;
      logic [31:0] dat;
      logic [31:0] exp;
   } pib_row_t;
   logic        sys_clk, rst, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
   logic [7:0]  wb_adr_i, aux_dac_o, ctrl;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [3:0]  wb_sel_i, v_chan_sel, stuck;
   logic [2:0]  t_chan_sel;
   logic        v_cmp_ov, v_cmp_uv, v_cmp_en, v_drive_hi, v_drive_lo;
   logic        v_sw_open, t_cmp_ot, t_cmp_ut, t_cmp_en, t_drive_hi;
   logic        t_drive_lo, t_pullup, fault_alert_pin_n, cell_uv;
   int          n_fail, comparisons;
   pib_row_t    rows [11];
   logic [7:0]  exp2 [6];

   pib_protector_bist #(.DWELL(DW), .PAR_CYC(PC)) dut (
      .sys_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
      .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .v_cmp_ov, .v_cmp_uv,
      .v_chan_sel, .v_cmp_en, .v_drive_hi, .v_drive_lo, .v_sw_open,
      .t_cmp_ot, .t_cmp_ut, .t_chan_sel, .t_cmp_en, .t_drive_hi,
      .t_drive_lo, .t_pullup, .aux_dac_o, .fault_alert_pin_n);
   pib_afe_model afe (
      .v_drive_hi, .v_drive_lo, .v_sw_open, .t_drive_hi, .t_drive_lo,
      .t_pullup, .stuck, .cell_uv, .v_cmp_ov, .v_cmp_uv, .t_cmp_ot,
      .t_cmp_ut);

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_up;
      n_fail++;
      $display("ERROR at %0t ns: wait ran out", $time);
      finish_test();
   endtask
   // Classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1)
         give_up();
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         wb(1'b0, `PIB_OFF_STATE, 32'h0);
         n++;
      end while (rd[6:0] !== 7'h00 && n < 100);
      if (rd[6:0] !== 7'h00)
         give_up();
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      stuck = 4'h0;
      cell_uv = 1'b0;
      rows = '{
         '{1'b0, `PIB_OFF_THR, 32'h0, 32'h0},
         '{1'b0, `PIB_OFF_CELLS, 32'h0, 32'hffff},
         '{1'b0, `PIB_OFF_GPIOCF, 32'h0, 32'h0},
         '{1'b0, 8'h30, 32'h0, 32'h0},
         '{1'b1, `PIB_OFF_THR, 32'h4b3c9664, 32'h0},
         '{1'b0, `PIB_OFF_THR, 32'h0, 32'h4b3c9664},
         '{1'b0, `PIB_OFF_STATE, 32'h0,
           32'h64 * `PIB_DAC_NUM / `PIB_DAC_DEN << 8},
         '{1'b1, `PIB_OFF_DIAG, 32'h2, 32'h0},
         '{1'b0, `PIB_OFF_STATE, 32'h0,
           32'h96 * `PIB_DAC_NUM / `PIB_DAC_DEN << 8},
         '{1'b1, `PIB_OFF_DIAG, 32'h4, 32'h0},
         '{1'b0, `PIB_OFF_STATE, 32'h0, 32'h3c00}};
      exp2 = '{8'h01, 8'h12, 8'h04, 8'h28, 8'h00, 8'h00};
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      chk(fault_alert_pin_n, 32'h1);
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].adr, rows[i].dat);
         if (!rows[i].we)
            chk(rd, rows[i].exp);
      end
      wb(1'b1, `PIB_OFF_TCTRL, 32'h17);
      chk(t_chan_sel, 32'h2);
      wb(1'b1, `PIB_OFF_DIAG, 32'h6);
      wb(1'b0, `PIB_OFF_STATE, 32'h0);
      chk(rd, 32'h4b10);
      chk(aux_dac_o, 32'h4b);
      wb(1'b1, `PIB_OFF_TCTRL, 32'h4);
      $display("Register and readback rows done");
      wb(1'b1, `PIB_OFF_CELLS, 32'h3);
      wb(1'b1, `PIB_OFF_GPIOCF, 32'h11);
      // Stuck comparators first, then one clean run of each protector
      for (int k = 0; k < 6; k++) begin
         stuck <= (k < 4) ? 4'h1 << k : 4'h0;
         ctrl = (k == 0 || k == 1 || k == 4) ?
                `PIB_OFF_VCTRL : `PIB_OFF_TCTRL;
         wb(1'b1, ctrl, 32'h6);
         wait_idle();
         wb(1'b0, `PIB_OFF_STAT2, 32'h0);
         chk(rd, {24'h0, exp2[k]});
         wb(1'b1, `PIB_OFF_STAT2, 32'h7f);
      end
      chk({v_cmp_en, t_cmp_en}, 32'h0);
      wb(1'b0, `PIB_OFF_UVFLG, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, `PIB_OFF_TFLG, 32'h0);
      chk(rd, 32'h0);
      $display("Self-test runs done");
      for (int i = 0; i < 2; i++) begin
         ctrl = i ? `PIB_OFF_TCTRL : `PIB_OFF_VCTRL;
         wb(1'b1, ctrl, 32'h6);
         wb(1'b1, ctrl, 32'h5);
         wb(1'b0, `PIB_OFF_STATE, 32'h0);
         chk(rd[6:0], i ? 32'h10 : 32'h01);
         wb(1'b1, ctrl, 32'h4);
      end
      $display("Go during self-test done");
      cell_uv <= 1'b1;
      wb(1'b1, `PIB_OFF_VCTRL, 32'h5);
      repeat (8 * DW) @(posedge sys_clk);
      wb(1'b1, `PIB_OFF_VCTRL, 32'h6);
      wait_idle();
      wb(1'b0, `PIB_OFF_STAT2, 32'h0);
      chk(rd, 32'h40);
      cell_uv <= 1'b0;
      wb(1'b1, `PIB_OFF_UVFLG, 32'hffff);
      wb(1'b1, `PIB_OFF_STAT2, 32'h7f);
      $display("Abort done");
      wb(1'b1, `PIB_OFF_DIAG, 32'h1);
      wb(1'b1, `PIB_OFF_VCTRL, 32'h6);
      wait_idle();
      wb(1'b0, `PIB_OFF_UVFLG, 32'h0);
      chk(rd, 32'h3);
      wb(1'b0, `PIB_OFF_OVFLG, 32'h0);
      chk(rd, 32'h3);
      chk(fault_alert_pin_n, 32'h0);
      wb(1'b1, `PIB_OFF_DIAG, 32'h0);
      wb(1'b1, `PIB_OFF_UVFLG, 32'hffff);
      wb(1'b1, `PIB_OFF_OVFLG, 32'hffff);
      $display("Keep-flags run done");
      // Clean parity first so an always-set flag cannot pass
      wb(1'b1, `PIB_OFF_VCTRL, 32'h5);
      wb(1'b1, `PIB_OFF_TCTRL, 32'h5);
      repeat (3 * PC) @(posedge sys_clk);
      wb(1'b0, `PIB_OFF_STAT1, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, `PIB_OFF_DIAG, 32'h8);
      repeat (3 * PC) @(posedge sys_clk);
      wb(1'b0, `PIB_OFF_STAT1, 32'h0);
      chk(rd, 32'h3);
      $display("Parity check done");
      // Reset while both engines run must stop them and clear flags
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      chk({v_cmp_en, t_cmp_en, fault_alert_pin_n}, 32'h1);
      wb(1'b0, `PIB_OFF_STAT1, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, `PIB_OFF_CELLS, 32'h0);
      chk(rd, 32'hffff);
      $display("Mid-run reset done");
      finish_test();
   end
endmodule // pib_protector_bist_test
